// ==== src/ppm_top.sv ====
// Pin function multiplexer for unbonded port-2 bits 6..7 and all port-3 pins.
// Assumes a serial unit on clk_sys; the serial clock pin is sampled, not used as a clock.
// Function
// (R1) Unbonded port-2 bits keep working interrupt flags
// (R2) Those flags change only by software write
// (R3) UART mode: serial clock pin input only
// (R4) SPI slave: external clock shifts data
// (R5) SPI master: drive shift clock on pin
// (R6) Transmit pin driven by serial transmit line
// (R7) Receive pin level feeds serial receive line
// (R8) Unbonded bits: output low, input unconnected
`timescale 1ns/1ns
`include "ppm_consts.svh"

module ppm_top (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	// Port-2 unbonded bits 7..6: software flag access and tied-off pad lines
	input  wire logic [1:0]           port2_flag_wr_en,
	input  wire logic [1:0]           port2_flag_wdata,
	input  wire logic [1:0]           port2_irq_enable,
	output logic      [1:0]           port2_irq_flag,
	output logic      [1:0]           port2_irq_req,
	output logic      [1:0]           port2_unbonded_out,
	output logic      [1:0]           port2_unbonded_oe,
	output logic      [1:0]           port2_unbonded_in,
	// Port-3 software control
	input  wire logic [7:0]           port3_function_select,
	input  wire logic [7:0]           port3_direction,
	input  wire logic [7:0]           port3_out_value,
	output logic      [7:0]           port3_in_value,
	// Port-3 pins
	input  wire logic [7:0]           p3_pin_in,
	output logic      [7:0]           p3_pin_out,
	output logic      [7:0]           p3_pin_oe,
	// Serial unit
	input  wire ppm_pkg::ppm_ser_out_s ser_out,
	output ppm_pkg::ppm_ser_in_s       ser_in
);
	logic [1:0]          flag_r;
	logic [1:0]          flag_nxt;
	logic [1:0]          unb_r;
	logic [7:0]          pin_sync;
	logic                clk_prev_r;
	ppm_pkg::ppm_pins_s  mod_drive;
	ppm_pkg::ppm_pins_s  pins_nxt;
	ppm_pkg::ppm_pins_s  pins_r;

	// Module-side drive of every port-3 pin for a given serial mode
	function automatic ppm_pkg::ppm_pins_s mod_pins(input ppm_pkg::ppm_ser_out_s s);
		ppm_pkg::ppm_pins_s p;
		p = '0;
		p.out[`PPM_P3_TXD] = s.serial_transmit_line;                 // R6
		p.oe[`PPM_P3_TXD]  = 1'b1;                                   // R6
		unique case (s.mode)
			ppm_pkg::MODE_UART: begin
				p.oe[`PPM_P3_CLK] = 1'b0;                              // R3
			end
			ppm_pkg::MODE_SPI_SLAVE: begin
				p.oe[`PPM_P3_CLK]   = 1'b0;                            // R4
				p.out[`PPM_P3_SOMI] = s.somi_out;
				p.oe[`PPM_P3_SOMI]  = 1'b1;
			end
			ppm_pkg::MODE_SPI_MASTER: begin
				p.out[`PPM_P3_CLK]  = s.sclk_out;                      // R5
				p.oe[`PPM_P3_CLK]   = 1'b1;                            // R5
				p.out[`PPM_P3_SIMO] = s.simo_out;
				p.oe[`PPM_P3_SIMO]  = 1'b1;
			end
			default: begin
				p.oe[`PPM_P3_CLK] = 1'b0;
			end
		endcase
		return p;
	endfunction

	// Pin inputs are asynchronous
	ppm_sync u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.d       (p3_pin_in),
		.q       (pin_sync)
	);

	// No pin event reaches these flags, so software is the only writer
	always_comb begin
		flag_nxt = flag_r;
		for (int i = 0; i < 2; i++) begin
			if (port2_flag_wr_en[i]) begin
				flag_nxt[i] = port2_flag_wdata[i];                  // R2
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			flag_r <= `PPM_FLAG_RST;
		end else begin
			flag_r <= flag_nxt;                                     // R1
		end
	end

	assign port2_irq_flag = flag_r;
	assign port2_irq_req  = flag_r & port2_irq_enable;             // R1

	// Unbonded bits never drive; held in a register kept at zero
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			unb_r <= `PPM_UNB_RST;
		end else begin
			unb_r <= `PPM_UNB_RST;                                  // R8
		end
	end

	assign port2_unbonded_out = unb_r;                             // R8
	assign port2_unbonded_oe  = unb_r;                             // R8
	assign port2_unbonded_in  = unb_r;                             // R8

	// Per-pin choice between software port and serial unit
	assign mod_drive = mod_pins(ser_out);

	// One continuous driver per bit; a process per pin would share one variable
	generate
		for (genvar g = 0; g < 8; g++) begin : g_pin
			assign pins_nxt.out[g] = port3_function_select[g] ?
				mod_drive.out[g] : port3_out_value[g];
			assign pins_nxt.oe[g]  = port3_function_select[g] ?
				mod_drive.oe[g] : port3_direction[g];
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pins_r <= '0;
		end else begin
			pins_r <= pins_nxt;
		end
	end

	assign p3_pin_out     = pins_r.out;
	assign p3_pin_oe      = pins_r.oe;
	assign port3_in_value = pin_sync;

	// Edge finder on the sampled serial clock; link clock must stay well below clk_sys/4
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			clk_prev_r <= 1'b0;
		end else begin
			clk_prev_r <= pin_sync[`PPM_P3_CLK];
		end
	end

	always_comb begin
		ser_in = '0;
		ser_in.slave_transmit_enable = pin_sync[`PPM_P3_STE];
		ser_in.simo_in               = pin_sync[`PPM_P3_SIMO];
		ser_in.somi_in               = pin_sync[`PPM_P3_SOMI];
		ser_in.sclk_in               = pin_sync[`PPM_P3_CLK];
		// Idle-high receive line keeps the UART from seeing a start bit
		ser_in.serial_receive_line = port3_function_select[`PPM_P3_RXD] ?
			pin_sync[`PPM_P3_RXD] : `PPM_RXD_IDLE;                  // R7
		if (ser_out.mode == ppm_pkg::MODE_SPI_SLAVE && port3_function_select[`PPM_P3_CLK]) begin
			ser_in.sclk_rise = pin_sync[`PPM_P3_CLK] & ~clk_prev_r;   // R4
			ser_in.sclk_fall = ~pin_sync[`PPM_P3_CLK] & clk_prev_r;   // R4
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	AST_FLAG_WRITE: assert property (                                // R1
		port2_flag_wr_en[0] |=> port2_irq_flag[0] == $past(port2_flag_wdata[0]))
		else $error("flag bit 6 did not take the written value");

	AST_FLAG7_WRITE: assert property (                               // R1
		port2_flag_wr_en[1] |=> port2_irq_flag[1] == $past(port2_flag_wdata[1]))
		else $error("flag bit 7 did not take the written value");

	AST_FLAG_ONLY_SW: assert property (                              // R2
		port2_flag_wr_en == 2'h0 |=> $stable(port2_irq_flag))
		else $error("flag changed without a software write");

	AST_IRQ_RAISE: assert property (                                 // R1
		port2_flag_wr_en[1] && port2_flag_wdata[1] && port2_irq_enable[1]
		##1 port2_irq_enable[1] |-> port2_irq_req[1])
		else $error("software flag did not raise interrupt request");

	AST_UART_CLK_IN: assert property (                               // R3
		ser_out.mode == ppm_pkg::MODE_UART && port3_function_select[3]
		|=> !p3_pin_oe[3])
		else $error("serial clock pin driven in UART mode");

	AST_SLAVE_CLK_IN: assert property (                              // R4
		ser_out.mode == ppm_pkg::MODE_SPI_SLAVE && port3_function_select[3]
		|=> !p3_pin_oe[3])
		else $error("serial clock pin driven in SPI slave mode");

	// Synchroniser and edge finder hold reset values for three edges after release
	AST_SLAVE_RISE: assert property (                                // R4
		ser_in.sclk_rise && $past(nrst) && $past(nrst, 2) && $past(nrst, 3)
		|-> $past(p3_pin_in[3], 2) && !$past(p3_pin_in[3], 3))
		else $error("slave rise pulse without a pin rising edge");

	AST_MASTER_CLK: assert property (                                // R5
		ser_out.mode == ppm_pkg::MODE_SPI_MASTER && port3_function_select[3]
		|=> p3_pin_oe[3] && p3_pin_out[3] == $past(ser_out.sclk_out))
		else $error("master shift clock not driven on pin");

	AST_TXD_ROUTE: assert property (                                 // R6
		port3_function_select[4]
		|=> p3_pin_oe[4] && p3_pin_out[4] == $past(ser_out.serial_transmit_line))
		else $error("transmit pin not following transmit line");

	AST_RXD_ROUTE: assert property (                                 // R7
		port3_function_select[5] && $past(nrst) && $past(nrst, 2)
		|-> ser_in.serial_receive_line == $past(p3_pin_in[5], 2))
		else $error("receive line does not follow receive pin");

	AST_UNBONDED_LOW: assert property (                              // R8
		port2_unbonded_out == 2'h0 && port2_unbonded_oe == 2'h0)
		else $error("unbonded port-2 bit drives");

	COV_UART: cover property (
		ser_out.mode == ppm_pkg::MODE_UART && port3_function_select[5] ##1 !ser_in.serial_receive_line);
	COV_MASTER: cover property (
		ser_out.mode == ppm_pkg::MODE_SPI_MASTER && port3_function_select[3] ##1 p3_pin_out[3]);
	COV_SLAVE_EDGE: cover property (ser_in.sclk_rise ##[1:40] ser_in.sclk_fall);
	COV_SW_IRQ: cover property (port2_flag_wr_en[0] && port2_flag_wdata[0] ##1 port2_irq_req[0]);

endmodule // ppm_top

// ==== src/ppm_consts.svh ====
// Constants of the port pin function multiplexer: pin positions, reset values and the idle receive level.
// Assumes inclusion by bare name from the design modules.
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

// Port-3 pin positions
`define PPM_P3_STE      3'h0
`define PPM_P3_SIMO     3'h1
`define PPM_P3_SOMI     3'h2
`define PPM_P3_CLK      3'h3
`define PPM_P3_TXD      3'h4
`define PPM_P3_RXD      3'h5

// Reset values and idle receive level
`define PPM_FLAG_RST    2'h0
`define PPM_EN_RST      2'h0
`define PPM_PIN8_RST    8'h00
`define PPM_UNB_RST     2'h0
`define PPM_RXD_IDLE    1'h1

`endif

// ==== src/ppm_pkg.sv ====
// Types of the port pin function multiplexer.
// Assumes nothing beyond the constants header.
package ppm_pkg;

	// Serial unit operating mode
	typedef enum logic [1:0] {
		MODE_UART,
		MODE_SPI_SLAVE,
		MODE_SPI_MASTER
	} ppm_mode_e;

	// Drive of eight pins: value and output enable
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} ppm_pins_s;

	// Lines that the serial unit drives towards the pins
	typedef struct packed {
		ppm_mode_e  mode;
		logic       serial_transmit_line;
		logic       sclk_out;
		logic       simo_out;
		logic       somi_out;
	} ppm_ser_out_s;

	// Lines handed to the serial unit from the pins
	typedef struct packed {
		logic       serial_receive_line;
		logic       slave_transmit_enable;
		logic       sclk_in;
		logic       sclk_rise;
		logic       sclk_fall;
		logic       simo_in;
		logic       somi_in;
	} ppm_ser_in_s;

endpackage

// ==== src/ppm_sync.sv ====
// Two-stage level synchroniser for pin inputs.
// Assumes inputs asynchronous to clk_sys; only the second stage is read outside.
`timescale 1ns/1ns
`include "ppm_consts.svh"

module ppm_sync (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	// Levels
	input  wire logic [7:0] d,
	output logic      [7:0] q
);
	logic [7:0] meta_r;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			meta_r <= `PPM_PIN8_RST;
			q      <= `PPM_PIN8_RST;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // ppm_sync

// ==== verif/ppm_far_model.sv ====
// Far-side serial device: pin levels and an external shift clock.
// Assumes the bench gives the other pin levels and a frame flag on clk_sys.
`timescale 1ns/1ns

module ppm_far_model (
	// Clock
	input  wire logic       clk_sys,
	// Control
	input  wire logic       frame,
	input  wire logic [7:0] lvl,
	// Pins
	output logic      [7:0] pin_in
);
	logic [2:0] cnt_r = 3'h0;
	logic       sclk_r = 1'b0;

	// Shift clock stands still between frames, 16 cycles a period
	always_ff @(posedge clk_sys) begin
		cnt_r <= frame ? cnt_r + 3'h1 : 3'h0;
		if (frame && cnt_r == 3'h7) begin
			sclk_r <= !sclk_r;
		end
	end

	assign pin_in = {lvl[7:4], sclk_r, lvl[2:0]};
endmodule // ppm_far_model

// ==== verif/tb_port_pin_function_mux.sv ====
// Self-checking bench of the pin function multiplexer.
// Assumes ppm_top and the far-side model; random stimulus from a fixed seed.
`timescale 1ns/1ns

module tb_port_pin_function_mux;
	logic                  clk_sys = 1'b0;
	logic                  nrst = 1'b0;
	logic [1:0]            wr_en = 2'h0, wdata = 2'h0, irq_en = 2'h0;
	logic [7:0]            sel = 8'h00, dir = 8'h00, ov = 8'h00, lvl = 8'h00;
	logic                  frame = 1'b0;
	ppm_pkg::ppm_ser_out_s so = '0;
	ppm_pkg::ppm_ser_in_s  si;
	logic [1:0]            flag, req, u_out, u_oe, u_in;
	logic [7:0]            in_val, pin_in, pin_out, pin_oe;
	logic [31:0]           seed = 32'h0000_b622;
	logic [1:0]            exp_flag = 2'h0;
	logic [23:0]           e;
	int                    fails = 0, tests_run = 0, rises = 0, pulses = 0, falls = 0;

	initial forever #5 clk_sys = !clk_sys;

	ppm_top dut (
		.clk_sys(clk_sys), .nrst(nrst), .port2_flag_wr_en(wr_en),
		.port2_flag_wdata(wdata), .port2_irq_enable(irq_en), .port2_irq_flag(flag),
		.port2_irq_req(req), .port2_unbonded_out(u_out), .port2_unbonded_oe(u_oe),
		.port2_unbonded_in(u_in), .port3_function_select(sel), .port3_direction(dir),
		.port3_out_value(ov), .port3_in_value(in_val), .p3_pin_in(pin_in),
		.p3_pin_out(pin_out), .p3_pin_oe(pin_oe), .ser_out(so), .ser_in(si)
	);

	ppm_far_model far (.clk_sys(clk_sys), .frame(frame), .lvl(lvl), .pin_in(pin_in));

	always @(posedge pin_in[3]) rises++;
	always @(negedge clk_sys) begin
		if (si.sclk_rise === 1'b1) pulses++;
		if (si.sclk_fall === 1'b1) falls++;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// Returns {checked out bits, out, oe}; out of undriven serial pins 1 to 3 is free
	function automatic logic [23:0] pin_exp(input logic [7:0] sl, d, v,
			input ppm_pkg::ppm_ser_out_s s);
		logic [7:0] o, oe, m;
		o = v & ~sl;
		oe = d & ~sl;
		m = oe | (sl & 8'he1);
		if (sl[4]) begin
			o[4] = s.serial_transmit_line;
			oe[4] = 1'b1;
			m[4] = 1'b1;
		end
		if (sl[3] && s.mode == ppm_pkg::MODE_SPI_MASTER) begin
			o[3] = s.sclk_out;
			oe[3] = 1'b1;
			m[3] = 1'b1;
		end
		if (sl[1] && s.mode == ppm_pkg::MODE_SPI_MASTER) begin
			o[1] = s.simo_out;
			oe[1] = 1'b1;
			m[1] = 1'b1;
		end
		if (sl[2] && s.mode == ppm_pkg::MODE_SPI_SLAVE) begin
			o[2] = s.somi_out;
			oe[2] = 1'b1;
			m[2] = 1'b1;
		end
		return {m, o, oe};
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Random step; held three edges so the pin synchroniser settles
	task automatic step;
		@(posedge clk_sys);
		seed = xs(seed);
		{wr_en, wdata, irq_en, sel, dir, ov} <= seed[29:0];
		exp_flag = (exp_flag & ~seed[29:28]) | (seed[27:26] & seed[29:28]);
		seed = xs(seed);
		{lvl, so.serial_transmit_line, so.sclk_out, so.simo_out, so.somi_out} <= seed[11:0];
		// All four codes, the unused one included; only the master code may drive the clock pin
		so.mode <= ppm_pkg::ppm_mode_e'(seed[13:12]);
		@(posedge clk_sys);
		wr_en <= 2'h0;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		e = pin_exp(sel, dir, ov, so);
		chk({6'h0, flag}, {6'h0, exp_flag});
		chk({6'h0, req}, {6'h0, exp_flag & irq_en});
		chk(pin_oe, e[7:0]);
		chk(pin_out & e[23:16], e[15:8] & e[23:16]);
		chk({2'h0, u_out, u_oe, u_in}, 8'h00);
		chk(in_val, pin_in);
		chk({7'h0, si.serial_receive_line}, {7'h0, !sel[5] | pin_in[5]});
		chk({4'h0, si.slave_transmit_enable, si.simo_in, si.somi_in, si.sclk_in},
			{4'h0, pin_in[0], pin_in[1], pin_in[2], pin_in[3]});
		chk({6'h0, si.sclk_rise, si.sclk_fall}, 8'h00);
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		@(negedge clk_sys);
		chk({flag, u_out, u_oe, u_in}, 8'h00);
		chk({7'h0, si.serial_receive_line}, 8'h01);
		repeat (300) step;
		// Reset in mid-run with random settings still applied
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		exp_flag = 2'h0;
		@(negedge clk_sys);
		chk({flag, req, u_out, u_oe}, 8'h00);
		chk(pin_oe, 8'h00);
		// Frames of external clock in every mode; edges reach the unit only as slave
		for (int m = 0; m < 3; m++) begin
			@(posedge clk_sys);
			so.mode <= ppm_pkg::ppm_mode_e'(m[1:0]);
			sel <= 8'hff;
			repeat (4) @(posedge clk_sys);
			rises = 0;
			pulses = 0;
			falls = 0;
			frame <= 1'b1;
			repeat (160) @(posedge clk_sys);
			frame <= 1'b0;
			repeat (20) @(posedge clk_sys);
			chk(8'(rises), 8'h0a);
			chk(8'(pulses), m == 1 ? 8'h0a : 8'h00);
			chk(8'(falls), m == 1 ? 8'h0a : 8'h00);
			chk({7'h0, pin_oe[3]}, {7'h0, m == 2});
		end
		complete_run;
	end

	initial begin
		repeat (4000) @(posedge clk_sys);
		fails++;
		complete_run;
	end
endmodule // tb_port_pin_function_mux
